// ==== bench/interlock_checker.sv ====
// Port-level assertions for the interlock output logic
module interlock_checker
	import interlock_pkg::*;
#(parameter logic [1:0] op_mode = 2'h1) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic safe_req_a_i,
	input wire logic bolt_cmd_a_i,
	input wire logic bolt_cmd_b_i,
	input wire logic ossd_a_o,
	input wire logic ossd_b_o,
	input wire logic door_closed_out_o,
	input wire logic bolt_engaged_out_o,
	input wire logic tag_presence_led_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	localparam bit M1 = (op_mode == 2'h1);
	logic [11:0] up_r;
	logic [5:0]  diff_r;
	////////////////////////////////////////
	// Saturating counts: cycles since release, cycles of disagreeing commands
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			up_r   <= 12'h0;
			diff_r <= 6'h0;
		end else begin
			up_r   <= up_r + {11'h0, ~&up_r};
			diff_r <= (bolt_cmd_a_i == bolt_cmd_b_i) ? 6'h0 : diff_r + {5'h0, ~&diff_r};
		end
	end
	// Output relations
	AST_OSSD_PAIR: assert property (M1 |-> ossd_a_o == ossd_b_o)
		else $error("safety channels differ in mode 1");
	AST_OSSD_LOCKED: assert property (M1 && ossd_a_o |-> bolt_engaged_out_o)
		else $error("safety output on without lock");
	AST_REQ_DROP: assert property ($fell(safe_req_a_i) |-> ##[1:5] !ossd_a_o)
		else $error("safety output late after request loss");
	AST_STARTUP_QUIET: assert property ({20'h0, up_r} < STARTUP_CYC |-> !(ossd_a_o ||
		ossd_b_o || door_closed_out_o || bolt_engaged_out_o))
		else $error("output active during start-up");
	AST_DOOR_LED: assert property (door_closed_out_o == tag_presence_led_o)
		else $error("door output and tag indicator disagree");
	AST_BOLT_DOOR: assert property (bolt_engaged_out_o |-> door_closed_out_o)
		else $error("bolt output without presence");
	AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
		else $error("bus slave stalled or erred");
	AST_INCOHERENT_OFF: assert property (diff_r > 6'd24 |-> !bolt_engaged_out_o)
		else $error("lock counted despite incoherent commands");
	// Main scenarios reached
	cover property (ossd_a_o && bolt_engaged_out_o);
	cover property ($fell(door_closed_out_o));
	cover property (diff_r == 6'd30);
endmodule : interlock_checker

bind rfid_interlock_output_logic interlock_checker #(.op_mode(op_mode)) i_interlock_checker (
	.clk_sys_i, .reset_n_i, .hreadyout_o, .hresp_o, .safe_req_a_i, .bolt_cmd_a_i, .bolt_cmd_b_i,
	.ossd_a_o, .ossd_b_o, .door_closed_out_o, .bolt_engaged_out_o, .tag_presence_led_o);

// ==== bench/ossd_partner.sv ====
// Behavioural safety module on the OSSD outputs, with relay feedback
module ossd_partner (
	input  wire logic clk_i,
	input  wire logic ossd_a_i,
	input  wire logic ossd_b_i,
	input  wire logic short_i,
	input  wire logic slow_i,
	output logic      sense_a_o,
	output logic      sense_b_o,
	output logic      feedback_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       on_r  = 1'b0;
	logic [7:0] age_r = 8'h0;
	initial feedback_o = 1'b1;
	// A short to ground holds channel a low whatever is driven
	assign sense_a_o = ossd_a_i & ~short_i;
	assign sense_b_o = ossd_b_i;
	// Relay contact follows after a settle time; slow exceeds the check window
	always @(posedge clk_i) begin
		on_r  <= ossd_a_i | ossd_b_i;
		age_r <= (on_r != (ossd_a_i | ossd_b_i)) ? 8'h0 : age_r + {7'h0, ~&age_r};
		if (age_r == (slow_i ? 8'd80 : 8'd5)) feedback_o <= ~on_r;
	end
endmodule : ossd_partner

// ==== bench/tb_rfid_interlock_output_logic.sv ====
// Self-checking bench of the interlock output logic in mode 1
module tb_rfid_interlock_output_logic import interlock_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
	logic        safe_req_a_i = 1'b1, safe_req_b_i = 1'b1, bolt_cmd_a_i = 1'b0;
	logic        bolt_cmd_b_i = 1'b0, supply_ok_i = 1'b1, tag_seen_i = 1'b0;
	logic        short_r = 1'b0, slow_r = 1'b0;
	logic [31:0] haddr_i = '0, hwdata_i = '0, tag_code_i = '0, hrdata_o, rd_v;
	logic [1:0]  htrans_i = 2'h0;
	logic [2:0]  hsize_i = 3'h2;
	logic [3:0]  tag_dist_i = 4'hf;
	logic        hreadyout_o, hresp_o, relay_feedback_check_i, ossd_a_sense_i, ossd_b_sense_i;
	logic        ossd_a_o, ossd_b_o, door_closed_out_o, bolt_engaged_out_o, solenoid_lock_o;
	logic        supply_led_o, input_led_o, output_led_o, tag_presence_led_o, lock_led_o;
	logic        feedback_led_o, m3_a, m3_b;
	int          fail_count = 0, comparisons = 0;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
	always #5 clk_sys_i = ~clk_sys_i;
	////////////////////////////////////////
	// Device under test and the safety module beside it
	rfid_interlock_output_logic #(.op_mode(2'h1), .edm_max_cyc(50)) i_rfid_interlock_output_logic (
		.clk_sys_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
		.hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .safe_req_a_i, .safe_req_b_i,
		.bolt_cmd_a_i, .bolt_cmd_b_i, .relay_feedback_check_i, .supply_ok_i, .ossd_a_sense_i,
		.ossd_b_sense_i, .tag_seen_i, .tag_code_i, .tag_dist_i, .ossd_a_o, .ossd_b_o,
		.door_closed_out_o, .bolt_engaged_out_o, .solenoid_lock_o, .supply_led_o, .input_led_o,
		.output_led_o, .tag_presence_led_o, .lock_led_o, .feedback_led_o);
	ossd_partner i_ossd_partner (.clk_i(clk_sys_i), .ossd_a_i(ossd_a_o), .ossd_b_i(ossd_b_o),
		.short_i(short_r), .slow_i(slow_r), .sense_a_o(ossd_a_sense_i),
		.sense_b_o(ossd_b_sense_i), .feedback_o(relay_feedback_check_i));
	// Mode 3 twin on the same pins; off the bus, so shared-code pairing and no feedback check
	rfid_interlock_output_logic #(.op_mode(2'h3), .edm_max_cyc(50)) i_rfid_interlock_output_logic_m3 (
		.clk_sys_i, .reset_n_i, .hsel_i(1'b0), .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
		.hready_i(1'b1), .hrdata_o(), .hreadyout_o(), .hresp_o(), .safe_req_a_i, .safe_req_b_i,
		.bolt_cmd_a_i, .bolt_cmd_b_i, .relay_feedback_check_i, .supply_ok_i,
		.ossd_a_sense_i(m3_a), .ossd_b_sense_i(m3_b), .tag_seen_i, .tag_code_i, .tag_dist_i,
		.ossd_a_o(m3_a), .ossd_b_o(m3_b), .door_closed_out_o(), .bolt_engaged_out_o(),
		.solenoid_lock_o(), .supply_led_o(), .input_led_o(), .output_led_o(),
		.tag_presence_led_o(), .lock_led_o(), .feedback_led_o());
	////////////////////////////////////////
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tk
	// Bounded wait for ready, giving up after 50 clock edges
	task automatic rdy();
		int n;
		n = 0;
		do begin @(posedge clk_sys_i); n++; end while (hreadyout_o !== 1'b1 && n < 50);
	endtask : rdy
	// One AHB-Lite single word transfer, read data left in rd_v
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		hsel_i   <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i  <= {24'h0, a};
		hwrite_i <= w;
		rdy();
		hsel_i   <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		rdy();
		rd_v = hrdata_o;
	endtask : bus
	// Show a tag, allow the presence path to settle, then look at the door output
	task automatic probe(input logic [31:0] c, input logic [3:0] d, input logic e);
		@(posedge clk_sys_i);
		tag_seen_i <= 1'b1;
		tag_code_i <= c;
		tag_dist_i <= d;
		tk(8);
		`CHK(door_closed_out_o, e)
	endtask : probe
	task automatic cmd(input logic a, input logic b);
		@(posedge clk_sys_i);
		bolt_cmd_a_i <= a;
		bolt_cmd_b_i <= b;
		tk(8);
	endtask : cmd
	// Reset with the far side back to healthy, then wait for the run state
	task automatic rst();
		int n;
		@(posedge clk_sys_i);
		reset_n_i  <= 1'b0;
		short_r    <= 1'b0;
		slow_r     <= 1'b0;
		tag_seen_i <= 1'b0;
		cmd(1'b0, 1'b0);
		reset_n_i <= 1'b1;
		for (n = 0; n < 3000 && supply_led_o !== 1'b1; n++) @(posedge clk_sys_i);
	endtask : rst
	task automatic close_out();
		if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	////////////////////////////////////////
	// Mode 1 sequence, pairing, incoherence, then one fault per fresh reset
	initial begin
		rst();
		bus(0, REG_TAG, 0);
		`CHK(rd_v, TAG_RST)
		bus(0, REG_STATUS, 0);
		`CHK(rd_v[13:10], 4'h5)
		bus(0, 8'h10, 0);
		`CHK(rd_v, 32'h0)
		bus(1, REG_CTRL, 32'h2);
		probe(SHARED_CODE, 4'h5, 1'b1);
		`CHK({tag_presence_led_o, bolt_engaged_out_o, ossd_a_o, feedback_led_o}, 4'b1001)
		`CHK({m3_a, m3_b}, 2'b01)
		cmd(1'b1, 1'b1);
		`CHK({bolt_engaged_out_o, ossd_a_o, ossd_b_o}, 3'b111)
		`CHK({lock_led_o, output_led_o, input_led_o, supply_led_o, solenoid_lock_o}, 5'h1f)
		`CHK({m3_a, m3_b}, 2'b11)
		probe(SHARED_CODE, 4'hc, 1'b1);
		safe_req_a_i <= 1'b0;
		tk(5);
		`CHK(ossd_a_o, 1'b0)
		`CHK({m3_a, m3_b}, 2'b01)
		safe_req_a_i <= 1'b1;
		cmd(1'b0, 1'b0);
		`CHK({door_closed_out_o, bolt_engaged_out_o, ossd_b_o}, 3'b000)
		probe(SHARED_CODE, 4'h8, 1'b0);
		probe(SHARED_CODE, 4'h5, 1'b1);
		bus(0, REG_STATUS, 0);
		`CHK(rd_v[8], 1'b0)
		bus(1, REG_CTRL, 32'h1);
		probe(SHARED_CODE, 4'h5, 1'b0);
		probe(32'h1234_0077, 4'h5, 1'b0);
		bus(1, REG_CTRL, 32'h5);
		bus(0, REG_TAG, 0);
		`CHK(rd_v, 32'h1234_0077)
		bus(0, REG_CTRL, 0);
		`CHK(rd_v[2:0], 3'h1)
		probe(32'h1234_0077, 4'h5, 1'b1);
		probe(32'h0bad_0c0d, 4'h5, 1'b0);
		bus(1, REG_CTRL, 32'h5);
		probe(32'h0bad_0c0d, 4'h5, 1'b1);
		probe(32'h1234_0077, 4'h5, 1'b0);
		bus(1, REG_CTRL, 32'h0);
		probe(SHARED_CODE, 4'h5, 1'b1);
		cmd(1'b1, 1'b1);
		cmd(1'b1, 1'b0);
		tk(24);
		bus(0, REG_STATUS, 0);
		`CHK({rd_v[6], bolt_engaged_out_o}, 2'b10)
		rst();
		bus(1, REG_CTRL, 32'h2);
		slow_r <= 1'b1;
		probe(SHARED_CODE, 4'h5, 1'b1);
		cmd(1'b1, 1'b1);
		tk(100);
		bus(0, REG_STATUS, 0);
		`CHK({rd_v[8], ossd_a_o}, 2'b10)
		rst();
		probe(SHARED_CODE, 4'h5, 1'b1);
		cmd(1'b1, 1'b1);
		short_r <= 1'b1;
		tk(30);
		short_r <= 1'b0;
		tk(30);
		bus(0, REG_STATUS, 0);
		`CHK({rd_v[11:10], rd_v[7], ossd_a_o}, 4'b1010)
		rst();
		supply_ok_i <= 1'b0;
		tk(4100);
		bus(0, REG_STATUS, 0);
		`CHK(rd_v[9], 1'b1)
		close_out();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#300_000;
		fail_count++;
		close_out();
	end
endmodule : tb_rfid_interlock_output_logic

// ==== hw/interlock_pkg.sv ====
// Constants, types and register map of the interlock output logic
package interlock_pkg;

	// Clock rate and derived time bases
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
	localparam int unsigned STARTUP_US     = 20;
	localparam int unsigned STARTUP_CYC    = STARTUP_US * CYC_PER_US;
	localparam int unsigned SELFTEST_US    = 40;
	localparam int unsigned SELFTEST_CYC   = SELFTEST_US * CYC_PER_US;
	localparam int unsigned EDM_MAX_MS     = 200;
	localparam int unsigned EDM_MAX_CYC    = EDM_MAX_MS * (CLK_HZ / 1_000);
	localparam int unsigned RESP_MAX_US    = 15000;
	localparam int unsigned FAULT_FILT_CYC = 16;
	localparam int unsigned CMD_DISC_CYC   = 16;

	// Detection distances in mm
	localparam logic [3:0] SAFE_UNLK_MM = 4'h6;
	localparam logic [3:0] SAFE_LK_MM   = 4'ha;
	localparam logic [3:0] DIFF_MM      = 4'h3;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TAG    = 8'h08;
	localparam logic [7:0] REG_LED    = 8'h0c;

	// Control field positions and reset values
	localparam int unsigned CTRL_UNIQUE = 0;
	localparam int unsigned CTRL_EDM    = 1;
	localparam int unsigned CTRL_LEARN  = 2;
	localparam logic [1:0]  CTRL_RST    = 2'h0;
	localparam logic [31:0] TAG_RST     = 32'h0000_0000;
	// Code carried by every shared-code tag; value is arbitrary
	localparam logic [31:0] SHARED_CODE = 32'h5a5a_0001;

	typedef enum logic [1:0] {ST_POWER_ON, ST_RUN, ST_ERROR} dev_state_type;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} ahb_req_type;

	typedef struct packed {
		logic ossd_a;
		logic ossd_b;
		logic door;
		logic bolt;
	} safety_out_type;

endpackage : interlock_pkg

// ==== hw/rfid_interlock_output_logic.sv ====
// Safety output decision, supervision and AHB-Lite register slave of the interlock
// Summary of operation
// R1: Mode 1: both OSSDs need both requests, present, locked
// R2: Mode 2: both OSSDs need both requests, present
// R3: Mode 3: ossd_a needs request a, present, locked
// R4: Mode 3: ossd_b needs request b, present only
// R5: Door output follows presence, bolt output follows lock
// R6: Entering safe area lights tag LED, door output
// R7: Lock command locks, enables outputs, widens area
// R8: Unlock command drops outputs, bolt, restores area
// R9: Leaving limit area clears tag LED, door output
// R10: Mode 2 outputs follow actuator detection directly
// R11: Shared-code pairing accepts any shared-code tag
// R12: Unique-code pairing accepts only the stored tag
// R13: Learning replaces stored code, repeatable
// R14: Supply monitored and cyclic self-test runs
// R15: Output faults and shorts detected on readback
// R16: Relay feedback must follow output changes
// R17: Disagreeing lock commands flag an incoherence
// R18: One indicator per internal function status
// R19: Outputs drop within 15 ms of request loss
// R20: Output fault latches error until restart
// R21: Outputs stay off until start-up test passes
// R22: Operating mode fixed at build time
// R23: Incoherent commands never count as locked
// R24: Lock commands are driven equal by the PLC
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
module rfid_interlock_output_logic
	import interlock_pkg::*;
#(
	parameter logic [1:0]  op_mode     = 2'h1,
	parameter int unsigned edm_max_cyc = EDM_MAX_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        safe_req_a_i,
	input  wire logic        safe_req_b_i,
	input  wire logic        bolt_cmd_a_i,
	input  wire logic        bolt_cmd_b_i,
	input  wire logic        relay_feedback_check_i,
	input  wire logic        supply_ok_i,
	input  wire logic        ossd_a_sense_i,
	input  wire logic        ossd_b_sense_i,
	input  wire logic        tag_seen_i,
	input  wire logic [31:0] tag_code_i,
	input  wire logic [3:0]  tag_dist_i,
	output logic             ossd_a_o,
	output logic             ossd_b_o,
	output logic             door_closed_out_o,
	output logic             bolt_engaged_out_o,
	output logic             solenoid_lock_o,
	output logic             supply_led_o,
	output logic             input_led_o,
	output logic             output_led_o,
	output logic             tag_presence_led_o,
	output logic             lock_led_o,
	output logic             feedback_led_o
);

	// Saturating 32-bit counter step
	function automatic logic [31:0] sat_inc(input logic [31:0] v);
		sat_inc = (v == 32'hffff_ffff) ? v : v + 32'h0000_0001;
	endfunction : sat_inc

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	localparam int unsigned NSYNC = 8;
	logic [NSYNC-1:0] pin_meta_r;
	logic [NSYNC-1:0] pin_sync_r;
	wire  [NSYNC-1:0] pin_raw = {ossd_b_sense_i, ossd_a_sense_i, supply_ok_i,
		relay_feedback_check_i, bolt_cmd_b_i, bolt_cmd_a_i, safe_req_b_i, safe_req_a_i};

	// Two stages; only the second stage is read by logic
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
		end
	end

	wire sreq_a    = pin_sync_r[0];
	wire sreq_b    = pin_sync_r[1];
	wire cmd_a     = pin_sync_r[2];
	wire cmd_b     = pin_sync_r[3];
	wire feedback  = pin_sync_r[4];
	wire supply_ok = pin_sync_r[5];
	wire sense_a   = pin_sync_r[6];
	wire sense_b   = pin_sync_r[7];

	////////////////////////////////////////////////////////////////////////////
	// Registers and state

	dev_state_type  state_r, state_nxt;
	safety_out_type out_r, out_nxt;
	ahb_req_type    req_r;
	logic [1:0]     ctrl_r;
	logic [31:0]    tag_code_r;
	logic [31:0]    hrdata_r;
	logic [31:0]    start_cnt_r, test_cnt_r, fault_cnt_r, edm_cnt_r, disc_cnt_r;
	logic           present_r, locked_r, incoh_r;
	logic           out_fault_r, edm_fault_r, supply_fault_r;
	logic [5:0]     led_r;

	////////////////////////////////////////////////////////////////////////////
	// Tag acceptance and detection area

	// Shared variant: fixed common code; unique variant: learnt code only
	wire code_match = ctrl_r[CTRL_UNIQUE] ? (tag_code_i == tag_code_r) // R12
	                                      : (tag_code_i == SHARED_CODE); // R11
	wire tag_ok     = tag_seen_i && code_match;
	wire lock_eff   = locked_r && !incoh_r; // R23
	// Mode 1 widens the safe area only while locked
	wire [3:0] safe_lim  = (op_mode == 2'h1 && !lock_eff) ? SAFE_UNLK_MM : SAFE_LK_MM; // R7 R8
	wire [3:0] limit_lim = safe_lim + DIFF_MM;
	wire enter_safe = tag_ok && (tag_dist_i <= safe_lim); // R6
	wire leave_lim  = !tag_ok || (tag_dist_i > limit_lim); // R9
	// Hysteresis: hold presence while inside the limit area
	wire present_nxt = enter_safe ? 1'b1 : (leave_lim ? 1'b0 : present_r);

	////////////////////////////////////////////////////////////////////////////
	// Lock command handling

	wire cmd_lock   = cmd_a && cmd_b;
	wire cmd_unlock = !cmd_a && !cmd_b;
	wire cmd_differ = cmd_a ^ cmd_b; // R17
	// Short skew between the two lines is tolerated before flagging
	wire incoh_nxt  = cmd_differ && (disc_cnt_r >= CMD_DISC_CYC);
	// Bolt can only be thrown onto a present actuator
	wire locked_nxt = present_nxt && (cmd_lock ? 1'b1 : (cmd_unlock ? 1'b0 : locked_r)); // R7 R8

	////////////////////////////////////////////////////////////////////////////
	// Output decision per mode

	wire run      = (state_r == ST_RUN);
	wire both_req = sreq_a && sreq_b;
	wire m1_on    = both_req && present_r && lock_eff; // R1
	wire m2_on    = both_req && present_r; // R2 R10
	wire m3_a_on  = sreq_a && present_r && lock_eff; // R3
	wire m3_b_on  = sreq_b && present_r; // R4
	wire dec_a    = (op_mode == 2'h1) ? m1_on : ((op_mode == 2'h2) ? m2_on : m3_a_on); // R22
	wire dec_b    = (op_mode == 2'h1) ? m1_on : ((op_mode == 2'h2) ? m2_on : m3_b_on);

	// Everything held low outside RUN; drops on the third clock edge after request loss at the pin
	always_comb begin
		out_nxt.ossd_a = run && dec_a; // R19 R21
		out_nxt.ossd_b = run && dec_b;
		out_nxt.door   = run && present_r; // R5 R6 R9
		out_nxt.bolt   = run && present_r && lock_eff; // R5 R7 R8
	end

	////////////////////////////////////////////////////////////////////////////
	// Supervision

	wire sense_mis  = (sense_a != out_r.ossd_a) || (sense_b != out_r.ossd_b); // R15
	wire relay_on   = out_r.ossd_a || out_r.ossd_b;
	// Feedback active means relay released, so it must be the inverse
	wire edm_mis    = ctrl_r[CTRL_EDM] && (feedback == relay_on); // R16
	wire test_tick  = (test_cnt_r >= SELFTEST_CYC - 1);
	wire out_fault_nxt    = out_fault_r || (run && fault_cnt_r >= FAULT_FILT_CYC); // R20
	wire edm_fault_nxt    = edm_fault_r || (run && edm_cnt_r >= edm_max_cyc); // R16
	wire supply_fault_nxt = supply_fault_r || (run && test_tick && !supply_ok); // R14

	// Power-on waits for the timer and a good supply; errors latch to reset
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_POWER_ON: begin
				if (start_cnt_r >= STARTUP_CYC && supply_ok) begin
					state_nxt = ST_RUN; // R21
				end
			end
			ST_RUN: begin
				if (out_fault_nxt || edm_fault_nxt || supply_fault_nxt) begin
					state_nxt = ST_ERROR; // R20
				end
			end
			default: begin
				state_nxt = ST_ERROR;
			end
		endcase
	end

	// Timers and counters
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_cnt_r <= '0;
			test_cnt_r  <= '0;
			fault_cnt_r <= '0;
			edm_cnt_r   <= '0;
			disc_cnt_r  <= '0;
		end else begin
			start_cnt_r <= sat_inc(start_cnt_r); // R21
			test_cnt_r  <= test_tick ? '0 : test_cnt_r + 32'h0000_0001; // R14
			fault_cnt_r <= sense_mis ? sat_inc(fault_cnt_r) : '0; // R15
			edm_cnt_r   <= edm_mis ? sat_inc(edm_cnt_r) : '0;
			disc_cnt_r  <= cmd_differ ? sat_inc(disc_cnt_r) : '0; // R17
		end
	end

	// Decision state
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r        <= ST_POWER_ON;
			out_r          <= '0;
			present_r      <= 1'b0;
			locked_r       <= 1'b0;
			incoh_r        <= 1'b0;
			out_fault_r    <= 1'b0;
			edm_fault_r    <= 1'b0;
			supply_fault_r <= 1'b0;
		end else begin
			state_r        <= state_nxt;
			out_r          <= out_nxt;
			present_r      <= present_nxt;
			locked_r       <= locked_nxt;
			incoh_r        <= incoh_nxt;
			out_fault_r    <= out_fault_nxt;
			edm_fault_r    <= edm_fault_nxt;
			supply_fault_r <= supply_fault_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Indicators: supply, inputs, tag, outputs, lock, feedback

	wire [5:0] led_nxt = {run && feedback, run && lock_eff, out_nxt.ossd_a || out_nxt.ossd_b,
		run && present_r, run && both_req, state_r != ST_POWER_ON}; // R18

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			led_r <= '0;
		end else begin
			led_r <= led_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states

	wire addr_take = hsel_i && hready_i && htrans_i[1];
	wire wr_data   = req_r.valid && req_r.write;
	wire wr_ctrl   = wr_data && (req_r.addr == REG_CTRL);
	// Learning needs a tag in the field at the moment of the write
	wire learn     = wr_ctrl && hwdata_i[CTRL_LEARN] && tag_seen_i; // R13
	wire [7:0] rd_addr = haddr_i[7:0];
	wire [31:0] status_word = {18'h0_0000, op_mode, state_r, supply_fault_r, edm_fault_r,
		out_fault_r, incoh_r, lock_eff, present_r, out_r.bolt, out_r.door,
		out_r.ossd_b, out_r.ossd_a};
	logic [31:0] rd_mux;

	// Unmapped and unaligned offsets read as zero
	always_comb begin
		if (rd_addr == REG_CTRL && haddr_i[31:8] == 24'h00_0000) begin
			rd_mux = {30'h0000_0000, ctrl_r};
		end else if (rd_addr == REG_STATUS && haddr_i[31:8] == 24'h00_0000) begin
			rd_mux = status_word;
		end else if (rd_addr == REG_TAG && haddr_i[31:8] == 24'h00_0000) begin
			rd_mux = tag_code_r;
		end else if (rd_addr == REG_LED && haddr_i[31:8] == 24'h00_0000) begin
			rd_mux = {26'h000_0000, led_r};
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	// Address phase capture and read data for the following data phase
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_r    <= '0;
			hrdata_r <= '0;
		end else begin
			req_r.valid <= addr_take;
			req_r.write <= hwrite_i;
			req_r.addr  <= (haddr_i[31:8] == 24'h00_0000) ? haddr_i[7:0] : 8'hff;
			hrdata_r    <= (addr_take && !hwrite_i) ? rd_mux : 32'h0000_0000;
		end
	end

	// Writable registers; the stored tag code may be relearnt at will
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_r     <= CTRL_RST;
			tag_code_r <= TAG_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= hwdata_i[1:0];
			end
			if (learn) begin
				tag_code_r <= tag_code_i; // R13
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output pins, all straight from flip-flops except the constant hreadyout_o and hresp_o

	assign hrdata_o           = hrdata_r;
	assign hreadyout_o        = 1'b1;
	assign hresp_o            = 1'b0;
	assign ossd_a_o           = out_r.ossd_a;
	assign ossd_b_o           = out_r.ossd_b;
	assign door_closed_out_o  = out_r.door;
	assign bolt_engaged_out_o = out_r.bolt;
	assign solenoid_lock_o    = locked_r;
	assign supply_led_o       = led_r[0];
	assign input_led_o        = led_r[1];
	assign tag_presence_led_o = led_r[2];
	assign output_led_o       = led_r[3];
	assign lock_led_o         = led_r[4];
	assign feedback_led_o     = led_r[5];

endmodule : rfid_interlock_output_logic
